// >>> verilog/ser_pkg.sv
package ser_pkg;

  // ==========================================================
  // Queue geometry
  localparam int unsigned QUEUE_DEPTH = 20;
  localparam int unsigned PTR_W = 5;
  localparam logic [4:0] QUEUE_LAST = 5'h13;
  localparam logic [4:0] QUEUE_FULL = 5'h14;
  localparam logic [4:0] PTR_ZERO = 5'h00;
  localparam int unsigned ERR_W = 16;
  localparam logic [15:0] NO_ERROR_CODE = 16'h0000;

  // ==========================================================
  // Status byte and event bit positions
  localparam int unsigned SB_SEC_BIT = 2;
  localparam int unsigned SB_ERR_BIT = 3;
  localparam int unsigned SB_PRI_BIT = 5;
  localparam int unsigned PRI_USER_REQ_BIT = 6;

  // ==========================================================
  // Reset values
  localparam logic [7:0] EVENT_RESET = 8'h00;
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [15:0] KEY_REPLY_RESET = 16'h0000;
  localparam logic [15:0] KNOB_NET_RESET = 16'h0000;

  // ==========================================================
  // Knob reply encoding
  localparam logic [15:0] KNOB_CCW_BASE = 16'h8000;
  localparam logic [15:0] KNOB_CW_MAX = 16'h0190;
  localparam logic [15:0] KNOB_CCW_MAX = 16'h7e6f;

  // ==========================================================
  // Enumerations
  typedef enum logic [1:0] {
    MSG_ERROR = 2'h0,
    MSG_WARNING = 2'h1,
    MSG_PROMPT = 2'h2,
    MSG_CAUTION = 2'h3
  } ser_msg_class_t;

  typedef enum logic [3:0] {
    CMD_READ_OLDEST_ERROR = 4'h0,
    CMD_CLEAR_STATUS = 4'h1,
    CMD_QUERY_PRIMARY = 4'h2,
    CMD_QUERY_SECONDARY = 4'h3,
    CMD_QUERY_KEY_CODE = 4'h4,
    CMD_GO_TO_LOCAL = 4'h5,
    CMD_SET_PRIMARY_ENABLE = 4'h6,
    CMD_SET_SECONDARY_ENABLE = 4'h7,
    CMD_READ_STATUS = 4'h8
  } ser_cmd_code_t;

  typedef enum logic [2:0] {
    RSP_ERROR = 3'h0,
    RSP_NO_ERRORS = 3'h1,
    RSP_EVENT_PRIMARY = 3'h2,
    RSP_EVENT_SECONDARY = 3'h3,
    RSP_KEY_CODE = 3'h4,
    RSP_STATUS = 3'h5
  } ser_rsp_kind_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FETCH = 2'b01,
    ST_ANSWER = 2'b11
  } ser_fsm_t;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic valid;
    ser_msg_class_t cls;
    logic [15:0] number;
  } ser_msg_t;

  typedef struct packed {
    logic valid;
    ser_cmd_code_t code;
    logic [7:0] data;
  } ser_cmd_t;

  typedef struct packed {
    logic valid;
    ser_rsp_kind_t kind;
    logic [15:0] data;
  } ser_rsp_t;

  typedef struct packed {
    logic key_valid;
    logic [14:0] key_code;
    logic knob_valid;
    logic knob_cw;
  } ser_panel_t;

endpackage : ser_pkg

// >>> verilog/ser_err_mem.sv
module ser_err_mem
  import ser_pkg::*;
(
  input wire logic mclk, // System clock
  input wire logic srst, // Synchronous reset
  input wire logic wr_en, // Write strobe
  input wire logic [4:0] wr_addr, // Write slot
  input wire logic [15:0] wr_data, // Error number written
  input wire logic [4:0] rd_addr, // Read slot
  output logic [15:0] rd_data // Registered read word
);

  typedef struct packed {
    logic [QUEUE_DEPTH-1:0][ERR_W-1:0] words;
    logic [ERR_W-1:0] rdata;
  } ser_mem_state_t;

  ser_mem_state_t m_q;
  ser_mem_state_t m_d;

  // ==========================================================
  // Storage: read sees the array as it was before this edge's write
  always_comb begin
    m_d = m_q;
    m_d.rdata = m_q.words[rd_addr];
    if (wr_en) begin
      m_d.words[wr_addr] = wr_data;
    end
  end

  // Cleared on reset so a stale slot never leaks out as an error number
  always_ff @(posedge mclk) begin
    if (srst) begin
      m_q <= '0;
    end else begin
      m_q <= m_d;
    end
  end

  assign rd_data = m_q.rdata;

endmodule : ser_err_mem

// >>> verilog/ser_status.sv
module ser_status
  import ser_pkg::*;
(
  input wire logic mclk, // System clock, 125 MHz
  input wire logic srst, // Synchronous reset, active high
  input wire logic preset_req, // Instrument preset pulse
  input wire ser_msg_t msg_i, // Displayed message strobe
  input wire ser_panel_t panel_i, // Front-panel key and knob strobes
  input wire logic [7:0] pri_cond_i, // Primary monitored conditions
  input wire logic [7:0] sec_cond_i, // Secondary monitored conditions
  input wire ser_cmd_t cmd_i, // Addressed command from controller
  input wire logic poll_req, // Serial poll request pulse
  output logic cmd_ready, // Ready to accept a command this cycle
  output ser_rsp_t rsp_o, // Command answer, valid one cycle
  output logic poll_valid, // Serial poll answer strobe
  output logic [7:0] poll_byte, // Serial poll answer
  output logic [7:0] status_byte, // Live status byte
  output logic remote, // Remote mode flag
  output logic key_exec_valid, // Local key function strobe
  output logic [14:0] key_exec_code, // Key for local execution
  output logic [4:0] queue_count // Entries in error queue
);

  // ==========================================================
  // State
  // Everything the block remembers except the error records travels in this one word, so
  // reset and the clock edge treat all of it alike
  typedef struct packed {
    ser_fsm_t fsm;
    logic fetch_hit;
    logic [4:0] rd_ptr;
    logic [4:0] wr_ptr;
    logic [4:0] count;
    logic [7:0] pri_latch;
    logic [7:0] sec_latch;
    logic [7:0] pri_enable;
    logic [7:0] sec_enable;
    logic [7:0] pri_prev;
    logic [7:0] sec_prev;
    logic [15:0] key_reply;
    logic [15:0] knob_net;
    logic remote;
    logic cmd_ready;
    ser_rsp_t rsp;
    logic poll_valid;
    logic [7:0] poll_byte;
    logic [7:0] status;
    logic key_exec_valid;
    logic [14:0] key_exec_code;
  } ser_state_t;

  // Registered state and its next value
  ser_state_t s_q;
  ser_state_t s_d;

  // Queue and latch controls decoded by the next-state logic
  logic push;
  logic pop;
  logic clr_queue;
  logic clr_pri;
  logic clr_sec;
  logic [7:0] pri_set;
  logic [7:0] sec_set;

  // Memory side: slot to write and the registered head record
  logic [4:0] wr_addr;
  logic [15:0] head_word;

  // ==========================================================
  // Helpers
  // Rising edge of a bank of condition levels
  // A level that stays high latches once, not on every cycle
  function automatic logic [7:0] onset(input logic [7:0] now, input logic [7:0] prev);
    onset = now & ~prev;
  endfunction : onset

  // Ring pointer advance over the 20 slots
  // Wraps at the last slot since the depth is not a power of two
  function automatic logic [4:0] next_ptr(input logic [4:0] p);
    next_ptr = (p == QUEUE_LAST) ? PTR_ZERO : p + 5'h01;
  endfunction : next_ptr

  // Knob reply: clockwise as minus count, counter-clockwise offset by 32768
  // The controller tells the two apart at -400, so the net count is held
  // inside its range before it reaches this encoding
  function automatic logic [15:0] knob_reply(input logic [15:0] net);
    if (!net[15]) begin
      knob_reply = 16'h0000 - net;
    end else begin
      knob_reply = KNOB_CCW_BASE + (16'h0000 - net);
    end
  endfunction : knob_reply

  // Any enabled latched bit raises the summary
  // Shared by the primary and the secondary summary bits
  function automatic logic summary(input logic [7:0] latch, input logic [7:0] en);
    summary = |(latch & en);
  endfunction : summary

  // ==========================================================
  // Next-state logic
  // One process owns every next value
  always_comb begin
    s_d = s_q;
    // Strobe outputs last one cycle unless raised again below
    s_d.rsp.valid = 1'b0;
    s_d.poll_valid = 1'b0;
    s_d.key_exec_valid = 1'b0;
    // Controls start idle; a preset always drops every queued record
    pop = 1'b0;
    clr_queue = preset_req;
    clr_pri = 1'b0;
    clr_sec = 1'b0;

    // Latch onsets; the user request bit also takes panel activity
    pri_set = onset(pri_cond_i, s_q.pri_prev);
    pri_set[PRI_USER_REQ_BIT] = pri_set[PRI_USER_REQ_BIT] | panel_i.key_valid
      | panel_i.knob_valid;
    sec_set = onset(sec_cond_i, s_q.sec_prev);
    // Remember this cycle's levels so only a fresh rise latches
    s_d.pri_prev = pri_cond_i;
    s_d.sec_prev = sec_cond_i;

    // Front panel: a key replaces any pending knob count
    // A key wins when both strobes arrive in one cycle
    if (panel_i.key_valid) begin
      s_d.key_reply = {1'b0, panel_i.key_code};
      s_d.knob_net = KNOB_NET_RESET;
      // In remote the key is only reported; local use is withheld
      if (!s_q.remote) begin
        s_d.key_exec_valid = 1'b1;
        s_d.key_exec_code = panel_i.key_code;
      end
    end else if (panel_i.knob_valid) begin
      // Saturate so the reply never crosses the -400 decode boundary
      // Clockwise stops at the largest count still read as clockwise
      if (panel_i.knob_cw) begin
        if (s_q.knob_net[15] || s_q.knob_net != KNOB_CW_MAX) begin
          s_d.knob_net = s_q.knob_net + 16'h0001;
        end
      end else begin
        // Counter-clockwise stops short of the offset's reach
        if (s_q.knob_net != (16'h0000 - KNOB_CCW_MAX)) begin
          s_d.knob_net = s_q.knob_net - 16'h0001;
        end
      end
      s_d.key_reply = knob_reply(s_d.knob_net);
    end

    // Serial poll answers from the registered byte, mode untouched
    // A poll may land while a command is in flight; it reads only the
    // registered byte, so neither side disturbs the other
    if (poll_req) begin
      s_d.poll_valid = 1'b1;
      s_d.poll_byte = s_q.status;
    end

    // Command sequencer
    unique case (s_q.fsm)
      ST_IDLE: begin
        if (cmd_i.valid) begin
          // Any addressed exchange takes the panel away; go-to-local
          // hands it straight back below
          s_d.remote = 1'b1;
          // Status reply by default; other answers overwrite it
          s_d.rsp.data = {8'h00, s_q.status};
          unique case (cmd_i.code)
            CMD_READ_OLDEST_ERROR: begin
              // Two extra cycles let the memory present the head record
              s_d.fsm = ST_FETCH;
            end
            CMD_CLEAR_STATUS: begin
              // Latches and queue go together; a preset clears only the queue
              clr_pri = 1'b1;
              clr_sec = 1'b1;
              clr_queue = 1'b1;
            end
            CMD_QUERY_PRIMARY: begin
              s_d.rsp.valid = 1'b1;
              s_d.rsp.kind = RSP_EVENT_PRIMARY;
              s_d.rsp.data = {8'h00, s_q.pri_latch};
              // Reading clears, but an onset in this cycle still lands
              clr_pri = 1'b1;
            end
            CMD_QUERY_SECONDARY: begin
              s_d.rsp.valid = 1'b1;
              s_d.rsp.kind = RSP_EVENT_SECONDARY;
              s_d.rsp.data = {8'h00, s_q.sec_latch};
              // Same read-to-clear behaviour as the primary register
              clr_sec = 1'b1;
            end
            CMD_QUERY_KEY_CODE: begin
              // Last key or net knob count; reading leaves it in place
              s_d.rsp.valid = 1'b1;
              s_d.rsp.kind = RSP_KEY_CODE;
              s_d.rsp.data = s_q.key_reply;
            end
            CMD_GO_TO_LOCAL: begin
              s_d.remote = 1'b0;
            end
            CMD_SET_PRIMARY_ENABLE: begin
              // Enables only steer the summary bits, never the latches
              s_d.pri_enable = cmd_i.data;
            end
            CMD_SET_SECONDARY_ENABLE: begin
              s_d.sec_enable = cmd_i.data;
            end
            CMD_READ_STATUS: begin
              // Data already holds the status byte; nothing is cleared
              s_d.rsp.valid = 1'b1;
              s_d.rsp.kind = RSP_STATUS;
            end
            default: begin
              // Unknown codes get no answer but still count as remote access
              s_d.rsp.valid = 1'b0;
            end
          endcase
        end
      end
      ST_FETCH: begin
        // Only entries visible before this edge are in the read word
        // The hit is fixed here so a later push cannot slip into the answer
        s_d.fetch_hit = (s_q.count != PTR_ZERO);
        s_d.fsm = ST_ANSWER;
      end
      ST_ANSWER: begin
        s_d.rsp.valid = 1'b1;
        // A preset landing now empties the queue, so answer no errors
        if (s_q.fetch_hit && !clr_queue) begin
          s_d.rsp.kind = RSP_ERROR;
          s_d.rsp.data = head_word;
          pop = 1'b1;
        end else begin
          s_d.rsp.kind = RSP_NO_ERRORS;
          s_d.rsp.data = NO_ERROR_CODE;
        end
        s_d.fsm = ST_IDLE;
      end
      default: begin
        // The unused code falls back to idle rather than locking up
        s_d.fsm = ST_IDLE;
      end
    endcase

    // Errors and warnings enter; prompts and cautions never do
    // A full queue refuses, unless a pop or clear frees a slot now
    push = msg_i.valid && (msg_i.cls == MSG_ERROR || msg_i.cls == MSG_WARNING)
      && (clr_queue || pop || s_q.count != QUEUE_FULL);

    // Queue pointers; a record arriving with a clear survives it
    // Count moves by one at most except on a clear, so full and empty never alias
    if (clr_queue) begin
      s_d.rd_ptr = PTR_ZERO;
      s_d.wr_ptr = push ? next_ptr(PTR_ZERO) : PTR_ZERO;
      s_d.count = push ? 5'h01 : PTR_ZERO;
    end else begin
      if (pop) begin
        s_d.rd_ptr = next_ptr(s_q.rd_ptr);
      end
      if (push) begin
        s_d.wr_ptr = next_ptr(s_q.wr_ptr);
      end
      if (push && !pop) begin
        s_d.count = s_q.count + 5'h01;
      end else if (pop && !push) begin
        s_d.count = s_q.count - 5'h01;
      end
    end

    // Latched events: a new onset wins over a same-cycle clear
    // Bits hold after the condition goes away until a read or a clear-status command clears them
    s_d.pri_latch = (s_q.pri_latch & ~{8{clr_pri}}) | pri_set;
    s_d.sec_latch = (s_q.sec_latch & ~{8{clr_sec}}) | sec_set;

    // Status byte built from the next state, so it changes on the same edge as the state
    // Bits other than the three summaries read as zero
    s_d.status = STATUS_RESET;
    s_d.status[SB_ERR_BIT] = (s_d.count != PTR_ZERO);
    s_d.status[SB_PRI_BIT] = summary(s_d.pri_latch, s_d.pri_enable);
    s_d.status[SB_SEC_BIT] = summary(s_d.sec_latch, s_d.sec_enable);


    // Ready is registered so the controller sees it settle with the state
    s_d.cmd_ready = (s_d.fsm == ST_IDLE);
  end

  // ==========================================================
  // Error record storage
  assign wr_addr = clr_queue ? PTR_ZERO : s_q.wr_ptr;

  // Head read is a cycle late, which the fetch state absorbs

  ser_err_mem u_err_mem (
    .mclk(mclk),
    .srst(srst),
    .wr_en(push),
    .wr_addr(wr_addr),
    .wr_data(msg_i.number),
    .rd_addr(s_q.rd_ptr),
    .rd_data(head_word)
  );

  // ==========================================================
  // State register
  always_ff @(posedge mclk) begin
    if (srst) begin
      // Constants only, field by field, so no stale value survives
      s_q.fsm <= ST_IDLE;
      s_q.fetch_hit <= 1'b0;
      s_q.rd_ptr <= PTR_ZERO;
      s_q.wr_ptr <= PTR_ZERO;
      s_q.count <= PTR_ZERO;
      s_q.pri_latch <= EVENT_RESET;
      s_q.sec_latch <= EVENT_RESET;
      s_q.pri_enable <= ENABLE_RESET;
      s_q.sec_enable <= ENABLE_RESET;
      s_q.pri_prev <= EVENT_RESET;
      s_q.sec_prev <= EVENT_RESET;
      s_q.key_reply <= KEY_REPLY_RESET;
      s_q.knob_net <= KNOB_NET_RESET;
      s_q.remote <= 1'b0;
      s_q.cmd_ready <= 1'b1;
      s_q.rsp <= '0;
      s_q.poll_valid <= 1'b0;
      s_q.poll_byte <= STATUS_RESET;
      s_q.status <= STATUS_RESET;
      s_q.key_exec_valid <= 1'b0;
      s_q.key_exec_code <= 15'h0000;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs, all straight from the state register
  assign cmd_ready = s_q.cmd_ready;
  assign rsp_o = s_q.rsp;
  assign poll_valid = s_q.poll_valid;
  assign poll_byte = s_q.poll_byte;
  assign status_byte = s_q.status;
  assign remote = s_q.remote;
  assign key_exec_valid = s_q.key_exec_valid;
  assign key_exec_code = s_q.key_exec_code;
  assign queue_count = s_q.count;

endmodule : ser_status

// >>> tb/ser_status_monitor.sv
// ==========
// Port checker for the status block
module ser_status_monitor
  import ser_pkg::*;
(
  input wire logic mclk, // Clock
  input wire logic srst, // Reset
  input wire logic preset_req, // Preset pulse
  input wire ser_msg_t msg_i, // Message strobe
  input wire ser_panel_t panel_i, // Panel strobes
  input wire logic [7:0] pri_cond_i, // Primary levels
  input wire logic [7:0] sec_cond_i, // Secondary levels
  input wire ser_cmd_t cmd_i, // Command
  input wire logic poll_req, // Poll request
  input wire logic cmd_ready, // Ready
  input wire ser_rsp_t rsp_o, // Answer
  input wire logic poll_valid, // Poll strobe
  input wire logic [7:0] poll_byte, // Poll answer
  input wire logic [7:0] status_byte, // Status byte
  input wire logic remote, // Remote flag
  input wire logic key_exec_valid, // Exec strobe
  input wire logic [14:0] key_exec_code, // Exec code
  input wire logic [4:0] queue_count // Queue fill
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);
  // Helpers; quiet excludes a pop or clear racing a push
  logic take;
  logic quiet;
  logic q_msg;
  assign take = cmd_i.valid && cmd_ready;
  assign quiet = cmd_ready && !cmd_i.valid && !preset_req;
  assign q_msg = msg_i.valid && (msg_i.cls == MSG_ERROR || msg_i.cls == MSG_WARNING);
  sequence s_rd;
    take && cmd_i.code == CMD_READ_OLDEST_ERROR;
  endsequence
  sequence s_busy;
    !cmd_ready [*2] ##1 (cmd_ready && rsp_o.valid);
  endsequence
  property p_poll;
    poll_req |=> poll_valid && poll_byte == $past(status_byte);
  endproperty
  a_poll: assert property (p_poll) else $error("poll answer wrong");
  property p_poll_mode;
    poll_req && !take |=> remote == $past(remote);
  endproperty
  a_poll_mode: assert property (p_poll_mode) else $error("poll moved mode");
  property p_remote;
    take && cmd_i.code != CMD_GO_TO_LOCAL |=> remote;
  endproperty
  a_remote: assert property (p_remote) else $error("no remote");
  property p_local;
    take && cmd_i.code == CMD_GO_TO_LOCAL |=> !remote;
  endproperty
  a_local: assert property (p_local) else $error("no local");
  property p_err_bit;
    status_byte[SB_ERR_BIT] == (queue_count != PTR_ZERO);
  endproperty
  a_err_bit: assert property (p_err_bit) else $error("error bit wrong");
  property p_push;
    quiet && q_msg && queue_count < QUEUE_FULL |=> queue_count == $past(queue_count) + 5'h01;
  endproperty
  a_push: assert property (p_push) else $error("error not queued");
  property p_drop;
    quiet && msg_i.valid && !q_msg |=> $stable(queue_count);
  endproperty
  a_drop: assert property (p_drop) else $error("prompt queued");
  property p_full;
    quiet && msg_i.valid && queue_count == QUEUE_FULL |=> queue_count == QUEUE_FULL;
  endproperty
  a_full: assert property (p_full) else $error("full queue changed");
  property p_rd;
    s_rd |=> s_busy;
  endproperty
  a_rd: assert property (p_rd) else $error("read timing wrong");
  property p_empty;
    s_rd ##1 (queue_count == PTR_ZERO) |=> ##1 (rsp_o.kind == RSP_NO_ERRORS && rsp_o.data == NO_ERROR_CODE);
  endproperty
  a_empty: assert property (p_empty) else $error("no-errors record wrong");
  property p_query;
    take && cmd_i.code == CMD_QUERY_PRIMARY |=> rsp_o.valid && rsp_o.kind == RSP_EVENT_PRIMARY;
  endproperty
  a_query: assert property (p_query) else $error("query answer wrong");
  property p_exec;
    panel_i.key_valid |=> key_exec_valid == !$past(remote);
  endproperty
  a_exec: assert property (p_exec) else $error("key exec wrong");
  property p_preset;
    preset_req |=> queue_count <= 5'h01;
  endproperty
  a_preset: assert property (p_preset) else $error("preset kept queue");
endmodule : ser_status_monitor

bind ser_status ser_status_monitor u_mon (.mclk(mclk), .srst(srst), .preset_req(preset_req),
  .msg_i(msg_i), .panel_i(panel_i), .pri_cond_i(pri_cond_i), .sec_cond_i(sec_cond_i),
  .cmd_i(cmd_i), .poll_req(poll_req), .cmd_ready(cmd_ready), .rsp_o(rsp_o),
  .poll_valid(poll_valid), .poll_byte(poll_byte), .status_byte(status_byte), .remote(remote),
  .key_exec_valid(key_exec_valid), .key_exec_code(key_exec_code), .queue_count(queue_count));

// >>> tb/ser_ctrl_model.sv
// ==========
// Bus controller issuing commands and polls
module ser_ctrl_model
  import ser_pkg::*;
(
  input wire logic mclk, // Clock
  input wire logic cmd_ready, // Device ready
  input wire ser_rsp_t rsp_o, // Device answer
  input wire logic poll_valid, // Poll strobe
  input wire logic [7:0] poll_byte, // Poll answer
  output ser_cmd_t cmd_i, // Command to device
  output logic poll_req // Poll request
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cmd_i = '0;
    poll_req = 1'b0;
  end
  // Hold until ready is seen; released data is inverted so stale values never match
  task automatic ask(input ser_cmd_code_t c, input logic [7:0] d, output ser_rsp_t r);
    @(posedge mclk);
    cmd_i <= '{1'b1, c, d};
    do @(posedge mclk); while (cmd_ready !== 1'b1);
    cmd_i <= '{1'b0, c, ~d};
    r = '0;
    for (int i = 0; i < 6 && r.valid !== 1'b1; i++) begin
      @(posedge mclk);
      r = rsp_o;
    end
  endtask : ask
  // Serial poll, answer taken one cycle after the request
  task automatic poll(output logic v, output logic [7:0] b);
    @(posedge mclk);
    poll_req <= 1'b1;
    @(posedge mclk);
    poll_req <= 1'b0;
    @(posedge mclk);
    v = poll_valid;
    b = poll_byte;
  endtask : poll
  // Knob reply decode as the controller does it
  function automatic int decode_knob(input logic [15:0] v);
    int s;
    s = int'($signed(v));
    if (s < -400) s = s + 32768;
    return s;
  endfunction : decode_knob
endmodule : ser_ctrl_model

// >>> tb/tb_ser_status.sv
// ==========
// Testbench
module tb_ser_status
  import ser_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin mismatches++; \
    $display("MISMATCH t=%0t got %0h exp %0h", $time, (a), (b)); end end
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic preset_req = 1'b0;
  ser_msg_t msg_i = '0;
  ser_panel_t panel_i = '0;
  logic [7:0] pri_cond_i = 8'h00;
  logic [7:0] sec_cond_i = 8'h00;
  ser_cmd_t cmd_i;
  logic poll_req;
  logic cmd_ready;
  ser_rsp_t rsp_o;
  logic poll_valid;
  logic [7:0] poll_byte;
  logic [7:0] status_byte;
  logic remote;
  logic key_exec_valid;
  logic [14:0] key_exec_code;
  logic [4:0] queue_count;
  int mismatches = 0;
  int total_checks = 0;
  ser_rsp_t r;
  logic e;
  logic [14:0] c;
  ser_status u_dut (.mclk(mclk), .srst(srst), .preset_req(preset_req), .msg_i(msg_i),
    .panel_i(panel_i), .pri_cond_i(pri_cond_i), .sec_cond_i(sec_cond_i), .cmd_i(cmd_i),
    .poll_req(poll_req), .cmd_ready(cmd_ready), .rsp_o(rsp_o), .poll_valid(poll_valid),
    .poll_byte(poll_byte), .status_byte(status_byte), .remote(remote),
    .key_exec_valid(key_exec_valid), .key_exec_code(key_exec_code), .queue_count(queue_count));
  ser_ctrl_model u_ctrl (.mclk(mclk), .cmd_ready(cmd_ready), .rsp_o(rsp_o),
    .poll_valid(poll_valid), .poll_byte(poll_byte), .cmd_i(cmd_i), .poll_req(poll_req));
  // 125 MHz clock
  initial begin
    forever #4 mclk = ~mclk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick
  task automatic msg(input ser_msg_class_t k, input logic [15:0] n);
    @(posedge mclk);
    msg_i <= '{1'b1, k, n};
    @(posedge mclk);
    msg_i <= '{1'b0, k, ~n};
  endtask : msg
  task automatic key(input logic [14:0] k);
    @(posedge mclk);
    panel_i <= '{1'b1, k, 1'b0, 1'b0};
    @(posedge mclk);
    panel_i <= '{1'b0, ~k, 1'b0, 1'b0};
    @(posedge mclk);
    e = key_exec_valid;
    c = key_exec_code;
  endtask : key
  task automatic knob(input logic cw);
    @(posedge mclk);
    panel_i <= '{1'b0, 15'h0000, 1'b1, cw};
    @(posedge mclk);
    panel_i.knob_valid <= 1'b0;
  endtask : knob
  task automatic t_reset();
    `CHK(status_byte, STATUS_RESET);
    `CHK(queue_count, PTR_ZERO);
    `CHK(remote, 1'b0);
    $display("test reset done");
  endtask : t_reset
  // Overfill, poll without leaving local, drain in order
  task automatic t_queue();
    for (int i = 0; i < 21; i++) msg(i[0] ? MSG_WARNING : MSG_ERROR, 16'(16'h0100 + i));
    msg(MSG_PROMPT, 16'h0200);
    msg(MSG_CAUTION, 16'h0201);
    tick(2);
    `CHK(queue_count, QUEUE_FULL);
    `CHK(status_byte[SB_ERR_BIT], 1'b1);
    u_ctrl.poll(e, c[7:0]);
    `CHK(e, 1'b1);
    `CHK(c[7:0], 8'h08);
    `CHK(remote, 1'b0);
    u_ctrl.ask(CMD_READ_STATUS, 8'h00, r);
    `CHK(r.kind, RSP_STATUS);
    `CHK(r.data, 16'h0008);
    `CHK(status_byte, 8'h08);
    for (int i = 0; i < 20; i++) begin
      u_ctrl.ask(CMD_READ_OLDEST_ERROR, 8'h00, r);
      `CHK(r.kind, RSP_ERROR);
      `CHK(r.data, 16'(16'h0100 + i));
    end
    `CHK(remote, 1'b1);
    `CHK(status_byte[SB_ERR_BIT], 1'b0);
    u_ctrl.ask(CMD_READ_OLDEST_ERROR, 8'h00, r);
    `CHK(r.kind, RSP_NO_ERRORS);
    $display("test queue done");
  endtask : t_queue
  task automatic t_clear();
    msg(MSG_ERROR, 16'h0011);
    msg(MSG_ERROR, 16'h0012);
    @(posedge mclk);
    preset_req <= 1'b1;
    @(posedge mclk);
    preset_req <= 1'b0;
    tick(2);
    `CHK(queue_count, PTR_ZERO);
    msg(MSG_WARNING, 16'h0013);
    u_ctrl.ask(CMD_CLEAR_STATUS, 8'h00, r);
    `CHK(queue_count, PTR_ZERO);
    $display("test clear done");
  endtask : t_clear
  // Conditions pulse and vanish; latches must hold until read
  task automatic t_events();
    @(posedge mclk);
    pri_cond_i <= 8'h02;
    sec_cond_i <= 8'h10;
    tick(2);
    pri_cond_i <= 8'h00;
    sec_cond_i <= 8'h00;
    u_ctrl.ask(CMD_SET_SECONDARY_ENABLE, 8'h10, r);
    `CHK(status_byte, 8'h04);
    u_ctrl.ask(CMD_SET_PRIMARY_ENABLE, 8'h42, r);
    `CHK(status_byte, 8'h24);
    u_ctrl.ask(CMD_QUERY_PRIMARY, 8'h00, r);
    `CHK(r.data, 16'h0002);
    u_ctrl.ask(CMD_QUERY_PRIMARY, 8'h00, r);
    `CHK(r.data, 16'h0000);
    u_ctrl.ask(CMD_CLEAR_STATUS, 8'h00, r);
    u_ctrl.ask(CMD_QUERY_SECONDARY, 8'h00, r);
    `CHK(r.data, 16'h0000);
    $display("test events done");
  endtask : t_events
  task automatic t_panel();
    u_ctrl.ask(CMD_GO_TO_LOCAL, 8'h00, r);
    `CHK(remote, 1'b0);
    key(15'h0021);
    `CHK(e, 1'b1);
    `CHK(c, 15'h0021);
    tick(2);
    `CHK(status_byte[SB_PRI_BIT], 1'b1);
    u_ctrl.ask(CMD_QUERY_KEY_CODE, 8'h00, r);
    `CHK(r.data, 16'h0021);
    key(15'h0033);
    `CHK(e, 1'b0);
    repeat (3) knob(1'b1);
    u_ctrl.ask(CMD_QUERY_KEY_CODE, 8'h00, r);
    `CHK(r.data, 16'hfffd);
    `CHK(u_ctrl.decode_knob(r.data), -3);
    key(15'h0034);
    repeat (2) knob(1'b0);
    u_ctrl.ask(CMD_QUERY_KEY_CODE, 8'h00, r);
    `CHK(r.data, 16'h8002);
    `CHK(u_ctrl.decode_knob(r.data), 2);
    $display("test panel done");
  endtask : t_panel
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude
  // Main sequence
  initial begin
    repeat (6) @(posedge mclk);
    srst <= 1'b0;
    tick(2);
    t_reset();
    t_queue();
    t_clear();
    t_events();
    t_panel();
    conclude();
  end
  // Whole run needs under 2000 cycles; a hang ends here
  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    conclude();
  end
endmodule : tb_ser_status
